// [design/frie_defines.vh]
// Constants for the file-register instruction execution block
`ifndef FRIE_DEFINES_VH
`define FRIE_DEFINES_VH

// Widths and stack depth
`define FRIE_OP_W          4
`define FRIE_ADDR_W        7
`define FRIE_DATA_W        8
`define FRIE_PC_W          13
`define FRIE_PADDR_W       12
`define FRIE_STACK_DEPTH   8
`define FRIE_STACK_PTR_W   3

// Decoded operation codes from the fetch stage
`define FRIE_OP_NOP        4'h0
`define FRIE_OP_INC        4'h1
`define FRIE_OP_OR         4'h2
`define FRIE_OP_MOVE       4'h3
`define FRIE_OP_LIT        4'h4
`define FRIE_OP_RETI       4'h5
`define FRIE_OP_STORE      4'h6
`define FRIE_OP_RETLIT     4'h7
`define FRIE_OP_SLEEP      4'h8
`define FRIE_OP_ROTL       4'h9

// Register byte offsets
`define FRIE_OFS_WREG      12'h000
`define FRIE_OFS_STATUS    12'h004
`define FRIE_OFS_STATE     12'h008

// Status register bit positions
`define FRIE_ST_CARRY      0
`define FRIE_ST_ZERO       2
`define FRIE_ST_PDOWN      3
`define FRIE_ST_TMOUT      4
`define FRIE_ST_GIE        7

// Reset values
`define FRIE_RST_WREG      8'h00
`define FRIE_RST_CARRY     1'b0
`define FRIE_RST_ZERO      1'b0
`define FRIE_RST_TMOUT     1'b1
`define FRIE_RST_PDOWN     1'b1
`define FRIE_RST_GIE       1'b0

`endif

// [design/frie_file_mem.v]
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module frie_file_mem #(
  parameter AW = 7,
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data <= {DW{1'b0}};
    end
    else if (rd_en)
    begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule // frie_file_mem

`default_nettype wire

// [design/frie_ret_stack.v]
// Circular return stack with registered top entry
`timescale 1ns/1ps
`default_nettype none

module frie_ret_stack #(
  parameter DEPTH = 8,
  parameter PTRW  = 3,
  parameter PW    = 13
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          push,
  input  wire [PW-1:0] push_data,
  input  wire          pop,
  output reg  [PW-1:0] return_stack_top
);

  reg  [PTRW-1:0]     ptr_reg;
  wire [DEPTH*PW-1:0] ent_flat;
  wire [PTRW-1:0]     below_top;

  assign below_top = ptr_reg - {{(PTRW-1){1'b0}}, 1'b1} - {{(PTRW-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Entries
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_ent
      reg [PW-1:0] ent_reg;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ent_reg <= {PW{1'b0}};
        end
        else if (push && !pop && (ptr_reg == i))
        begin
          ent_reg <= push_data;
        end
      end
      assign ent_flat[i*PW +: PW] = ent_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and top
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_reg          <= {PTRW{1'b0}};
      return_stack_top <= {PW{1'b0}};
    end
    else if (pop)
    begin
      ptr_reg          <= ptr_reg - {{(PTRW-1){1'b0}}, 1'b1};
      return_stack_top <= ent_flat[below_top*PW +: PW];
    end
    else if (push)
    begin
      ptr_reg          <= ptr_reg + {{(PTRW-1){1'b0}}, 1'b1};
      return_stack_top <= push_data;
    end
  end

endmodule // frie_ret_stack

`default_nettype wire

// [design/frie_exec.v]
// Execution unit for file-register, literal, return and sleep instructions
`timescale 1ns/1ps
`default_nettype none
`include "frie_defines.vh"

module frie_exec #(
  parameter STACK_DEPTH = `FRIE_STACK_DEPTH,
  parameter STACK_PTR_W = `FRIE_STACK_PTR_W
) (
  input  wire                       pclk,
  input  wire                       presetn,
  input  wire                       psel,
  input  wire                       penable,
  input  wire                       pwrite,
  input  wire [`FRIE_PADDR_W-1:0]   paddr,
  input  wire [31:0]                pwdata,
  output reg  [31:0]                prdata,
  output reg                        pready,
  output reg                        pslverr,
  input  wire                       instr_valid,
  output reg                        instr_ready,
  input  wire [`FRIE_OP_W-1:0]      instr_op,
  input  wire [`FRIE_ADDR_W-1:0]    instr_addr,
  input  wire                       instr_dest,
  input  wire [`FRIE_DATA_W-1:0]    instr_lit,
  input  wire                       stack_push,
  input  wire [`FRIE_PC_W-1:0]      stack_push_data,
  input  wire                       wake_req,
  output reg                        pc_advance,
  output reg                        pc_load,
  output reg  [`FRIE_PC_W-1:0]      pc_load_value,
  output reg                        fetch_flush,
  output reg                        global_interrupt_enable,
  output reg                        sleep_active,
  output reg                        watchdog_timer_clear,
  output reg                        prescaler_clear
);

  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_EXEC  = 4'h2;
  localparam [3:0] S_FLUSH = 4'h4;
  localparam [3:0] S_SLEEP = 4'h8;

  reg  [3:0]               state_reg;
  reg  [3:0]               state_next;
  reg  [`FRIE_OP_W-1:0]    op_reg;
  reg  [`FRIE_ADDR_W-1:0]  addr_reg;
  reg                      dest_reg;
  reg  [`FRIE_DATA_W-1:0]  lit_reg;
  reg  [`FRIE_DATA_W-1:0]  wreg_reg;
  reg  [`FRIE_DATA_W-1:0]  wreg_next;
  reg                      carry_reg;
  reg                      carry_next;
  reg                      zero_reg;
  reg                      zero_next;
  reg                      timeout_status_bit;
  reg                      tmout_next;
  reg                      powerdown_status_bit;
  reg                      pdown_next;
  reg                      gie_next;
  reg                      wake_meta_reg;
  reg                      wake_sync_reg;
  reg                      file_wr_en;
  reg  [`FRIE_DATA_W-1:0]  file_wr_data;
  reg  [`FRIE_DATA_W-1:0]  result;
  reg                      route_result;
  reg                      stack_pop;
  reg                      adv_next;
  reg                      load_next;
  reg                      flush_next;
  reg                      wdt_next;
  reg  [31:0]              rdata_next;
  reg                      err_next;
  wire [`FRIE_DATA_W-1:0]  file_value;
  wire [`FRIE_PC_W-1:0]    return_stack_top;
  wire                     accept;
  wire                     apb_setup;
  wire                     apb_write;
  wire [`FRIE_DATA_W-1:0]  status_value;

  assign accept    = instr_valid && instr_ready && state_reg[0];
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;

  assign status_value = {global_interrupt_enable, 2'b00, timeout_status_bit,
                         powerdown_status_bit, zero_reg, 1'b0, carry_reg};

  ////////////////////////////////////////////////////////////////////////////
  // File register space and return stack
  frie_file_mem #(
    .AW (`FRIE_ADDR_W),
    .DW (`FRIE_DATA_W)
  ) u_file_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (file_wr_en),
    .wr_addr (addr_reg),
    .wr_data (file_wr_data),
    .rd_en   (accept),
    .rd_addr (instr_addr),
    .rd_data (file_value)
  );

  frie_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .PTRW  (STACK_PTR_W),
    .PW    (`FRIE_PC_W)
  ) u_ret_stack (
    .pclk             (pclk),
    .presetn          (presetn),
    .push             (stack_push),
    .push_data        (stack_push_data),
    .pop              (stack_pop),
    .return_stack_top (return_stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Execution next state
  always @*
  begin
    state_next   = state_reg;
    wreg_next    = wreg_reg;
    carry_next   = carry_reg;
    zero_next    = zero_reg;
    tmout_next   = timeout_status_bit;
    pdown_next   = powerdown_status_bit;
    gie_next     = global_interrupt_enable;
    file_wr_en   = 1'b0;
    file_wr_data = file_value;
    result       = file_value;
    route_result = 1'b0;
    stack_pop    = 1'b0;
    adv_next     = 1'b0;
    load_next    = 1'b0;
    flush_next   = 1'b0;
    wdt_next     = 1'b0;
    // Software writes first, execution overrides
    if (apb_write && (paddr == `FRIE_OFS_WREG))
    begin
      wreg_next = pwdata[`FRIE_DATA_W-1:0];
    end
    if (apb_write && (paddr == `FRIE_OFS_STATUS))
    begin
      carry_next = pwdata[`FRIE_ST_CARRY];
      zero_next  = pwdata[`FRIE_ST_ZERO];
      gie_next   = pwdata[`FRIE_ST_GIE];
    end
    case (state_reg)
      S_IDLE:
      begin
        if (accept)
        begin
          state_next = S_EXEC;
        end
      end
      S_EXEC:
      begin
        state_next = S_IDLE;
        adv_next   = 1'b1;
        case (op_reg)
          `FRIE_OP_INC:
          begin
            result       = file_value + 8'h01;
            route_result = 1'b1;
            zero_next    = (result == 8'h00);
          end
          `FRIE_OP_OR:
          begin
            result       = wreg_reg | file_value;
            route_result = 1'b1;
            zero_next    = (result == 8'h00);
          end
          `FRIE_OP_MOVE:
          begin
            result       = file_value;
            route_result = 1'b1;
            zero_next    = (result == 8'h00);
          end
          `FRIE_OP_LIT:
          begin
            wreg_next = lit_reg;
          end
          `FRIE_OP_RETI:
          begin
            adv_next   = 1'b0;
            load_next  = 1'b1;
            stack_pop  = 1'b1;
            gie_next   = 1'b1;
            state_next = S_FLUSH;
          end
          `FRIE_OP_STORE:
          begin
            file_wr_en   = 1'b1;
            file_wr_data = wreg_reg;
          end
          `FRIE_OP_RETLIT:
          begin
            adv_next   = 1'b0;
            wreg_next  = lit_reg;
            load_next  = 1'b1;
            stack_pop  = 1'b1;
            state_next = S_FLUSH;
          end
          `FRIE_OP_SLEEP:
          begin
            wdt_next   = 1'b1;
            tmout_next = 1'b1;
            pdown_next = 1'b0;
            state_next = S_SLEEP;
          end
          `FRIE_OP_ROTL:
          begin
            result       = {file_value[6:0], carry_reg};
            carry_next   = file_value[7];
            route_result = 1'b1;
          end
          default:
          begin
            adv_next = 1'b1;
          end
        endcase
        // Destination routing
        if (route_result)
        begin
          if (dest_reg)
          begin
            file_wr_en   = 1'b1;
            file_wr_data = result;
          end
          else
          begin
            wreg_next = result;
          end
        end
      end
      S_FLUSH:
      begin
        flush_next = 1'b1;
        state_next = S_IDLE;
      end
      S_SLEEP:
      begin
        if (wake_sync_reg)
        begin
          state_next = S_IDLE;
        end
      end
      default:
      begin
        state_next = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data
  always @*
  begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (paddr)
      `FRIE_OFS_WREG:   rdata_next = {24'h00_0000, wreg_reg};
      `FRIE_OFS_STATUS: rdata_next = {24'h00_0000, status_value};
      `FRIE_OFS_STATE:  rdata_next = {27'h000_0000, !instr_ready, state_reg};
      default:          err_next   = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg               <= S_IDLE;
      op_reg                  <= `FRIE_OP_NOP;
      addr_reg                <= 7'h00;
      dest_reg                <= 1'b0;
      lit_reg                 <= 8'h00;
      wreg_reg                <= `FRIE_RST_WREG;
      carry_reg               <= `FRIE_RST_CARRY;
      zero_reg                <= `FRIE_RST_ZERO;
      timeout_status_bit      <= `FRIE_RST_TMOUT;
      powerdown_status_bit    <= `FRIE_RST_PDOWN;
      global_interrupt_enable <= `FRIE_RST_GIE;
      wake_meta_reg           <= 1'b0;
      wake_sync_reg           <= 1'b0;
      instr_ready             <= 1'b0;
      pc_advance              <= 1'b0;
      pc_load                 <= 1'b0;
      pc_load_value           <= 13'h0000;
      fetch_flush             <= 1'b0;
      sleep_active            <= 1'b0;
      watchdog_timer_clear    <= 1'b0;
      prescaler_clear         <= 1'b0;
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end
    else
    begin
      state_reg               <= state_next;
      wreg_reg                <= wreg_next;
      carry_reg               <= carry_next;
      zero_reg                <= zero_next;
      timeout_status_bit      <= tmout_next;
      powerdown_status_bit    <= pdown_next;
      global_interrupt_enable <= gie_next;
      wake_meta_reg           <= wake_req;
      wake_sync_reg           <= wake_meta_reg;
      if (accept)
      begin
        op_reg   <= instr_op;
        addr_reg <= instr_addr;
        dest_reg <= instr_dest;
        lit_reg  <= instr_lit;
      end
      instr_ready          <= state_next[0] && !accept;
      pc_advance           <= adv_next;
      pc_load              <= load_next;
      pc_load_value        <= load_next ? return_stack_top : pc_load_value;
      fetch_flush          <= flush_next;
      sleep_active         <= state_next[3];
      watchdog_timer_clear <= wdt_next;
      prescaler_clear      <= wdt_next;
      pready               <= apb_setup && !pready;
      if (apb_setup)
      begin
        prdata  <= rdata_next;
        pslverr <= err_next;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // frie_exec

`default_nettype wire

// [tb/frie_exec_monitor.sv]
// Port checker for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "frie_defines.vh"

module frie_exec_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [3:0]  instr_op,
  input wire logic        wake_req,
  input wire logic        pc_advance,
  input wire logic        pc_load,
  input wire logic        fetch_flush,
  input wire logic        global_interrupt_enable,
  input wire logic        sleep_active,
  input wire logic        watchdog_timer_clear,
  input wire logic        prescaler_clear
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire take = instr_valid && instr_ready;
  wire ret  = instr_op == `FRIE_OP_RETLIT || instr_op == `FRIE_OP_RETI;
  ////////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  AST_APB_UNMAPPED: assert property (psel && !penable && paddr > 12'h008 |=> pslverr)
    else $error("unmapped access not refused");
  AST_NOP_ADVANCE: assert property (
    take && instr_op == `FRIE_OP_NOP |=> !instr_ready ##1 pc_advance && !pc_load)
    else $error("nop did not advance");
  AST_RET_RELOAD: assert property (
    take && ret |=> !pc_load ##1 pc_load && !pc_advance ##1 fetch_flush && !pc_load)
    else $error("return reload sequence wrong");
  AST_RETI_ENABLE: assert property (
    take && instr_op == `FRIE_OP_RETI |-> ##2 global_interrupt_enable)
    else $error("interrupt enable not set");
  AST_FLUSH_IDLE: assert property (
    fetch_flush |-> $past(pc_load) && !pc_advance && !pc_load)
    else $error("flush cycle executed");
  AST_SLEEP_ENTRY: assert property (
    take && instr_op == `FRIE_OP_SLEEP |-> ##2 sleep_active && watchdog_timer_clear)
    else $error("sleep entry wrong");
  AST_CLEAR_PAIR: assert property (
    watchdog_timer_clear == prescaler_clear && watchdog_timer_clear == $rose(sleep_active))
    else $error("watchdog clear mismatch");
  AST_SLEEP_HALT: assert property (
    sleep_active && !$rose(sleep_active) |-> !instr_ready && !pc_advance && !pc_load)
    else $error("activity while asleep");
  AST_WAKE_BOUND: assert property (
    $rose(wake_req) && sleep_active |-> ##[1:5] !sleep_active)
    else $error("wake not taken");
  COV_SLEEP: cover property (take && instr_op == `FRIE_OP_SLEEP);
  COV_FLUSH: cover property (fetch_flush);
  COV_ERR: cover property (pready && pslverr);
endmodule // frie_exec_monitor

bind frie_exec frie_exec_monitor frie_exec_monitor_i (.*);
`default_nettype wire

// [tb/frie_fetch_model.sv]
// Fetch stage model offering decoded instructions
`timescale 1ns/1ps
`default_nettype none

module frie_fetch_model (
  input  wire logic       pclk,
  input  wire logic       instr_ready,
  output var  logic       instr_valid,
  output var  logic [3:0] instr_op,
  output var  logic [6:0] instr_addr,
  output var  logic       instr_dest,
  output var  logic [7:0] instr_lit
);
  initial
  begin
    {instr_valid, instr_op, instr_addr, instr_dest, instr_lit} = '0;
  end
  // Offer after a stall, hold until taken
  task automatic issue(input logic [3:0] op, input logic [6:0] a, input logic d,
                       input logic [7:0] k, input int stall);
    repeat (stall) @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_addr  <= a;
    instr_dest  <= d;
    instr_lit   <= k;
    do @(posedge pclk); while (instr_ready !== 1'b1);
    // Released fields show inverted values
    instr_valid <= 1'b0;
    instr_op    <= ~op;
    instr_addr  <= ~a;
    instr_dest  <= ~d;
    instr_lit   <= ~k;
  endtask
endmodule // frie_fetch_model
`default_nettype wire

// [tb/frie_exec_tb.sv]
// Self-checking testbench for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "frie_defines.vh"

module frie_exec_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        instr_valid, instr_ready, instr_dest, stack_push, wake_req;
  logic [3:0]  instr_op;
  logic [6:0]  instr_addr;
  logic [7:0]  instr_lit, w_m;
  logic [7:0]  mem_m [128];
  logic [12:0] stack_push_data, pc_load_value, pcv;
  logic        pc_advance, pc_load, fetch_flush, global_interrupt_enable, sleep_active;
  logic        watchdog_timer_clear, prescaler_clear, c_m, z_m, gie_m, pd_m;
  logic [3:0]  ops [9] = '{`FRIE_OP_NOP, `FRIE_OP_INC, `FRIE_OP_OR, `FRIE_OP_MOVE,
    `FRIE_OP_LIT, `FRIE_OP_RETI, `FRIE_OP_STORE, `FRIE_OP_RETLIT, `FRIE_OP_ROTL};
  int          n_errors, cmp_count, cyc, j;

  frie_exec frie_exec_i (.*);
  frie_fetch_model frie_fetch_model_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] st_exp();
    return {24'h0, gie_m, 2'b00, 1'b1, pd_m, z_m, 1'b0, c_m};
  endfunction
  // Result with new zero and carry
  function automatic logic [9:0] calc(input logic [3:0] op, input logic [7:0] f);
    logic [7:0] r;
    r = op == `FRIE_OP_INC ? f + 8'h01 : op == `FRIE_OP_OR ? (w_m | f) :
        op == `FRIE_OP_ROTL ? {f[6:0], c_m} : f;
    if (op == `FRIE_OP_ROTL)
      return {z_m, f[7], r};
    return {r == 8'h00, c_m, r};
  endfunction
  task automatic run_op(input logic [3:0] op, input logic [6:0] a, input logic d,
                        input logic [7:0] k);
    logic [9:0]  q;
    logic [12:0] p;
    p = 13'($urandom);
    if (op == `FRIE_OP_RETLIT || op == `FRIE_OP_RETI)
    begin
      stack_push_data <= p;
      stack_push      <= 1'b1;
      @(posedge pclk);
      stack_push <= 1'b0;
    end
    frie_fetch_model_i.issue(op, a, d, k, $urandom % 3);
    do
    begin
      @(posedge pclk);
      if (pc_load === 1'b1)
        pcv = pc_load_value;
    end
    while (instr_ready !== 1'b1);
    q = calc(op, mem_m[a]);
    case (op)
      `FRIE_OP_INC, `FRIE_OP_OR, `FRIE_OP_MOVE, `FRIE_OP_ROTL:
      begin
        {z_m, c_m} = q[9:8];
        if (d)
          mem_m[a] = q[7:0];
        else
          w_m = q[7:0];
      end
      `FRIE_OP_LIT, `FRIE_OP_RETLIT: w_m = k;
      `FRIE_OP_STORE: mem_m[a] = w_m;
      `FRIE_OP_RETI: gie_m = 1'b1;
      default: ;
    endcase
    if (op == `FRIE_OP_RETLIT || op == `FRIE_OP_RETI)
      chk({19'h0, pcv}, {19'h0, p});
    chk_reg(`FRIE_OFS_WREG, {24'h0, w_m});
    chk_reg(`FRIE_OFS_STATUS, st_exp());
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {stack_push, stack_push_data, wake_req} = '0;
    {w_m, c_m, z_m, gie_m, pd_m} = 12'h001;
    j = $urandom(23);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(`FRIE_OFS_WREG, 32'h0);
    chk_reg(`FRIE_OFS_STATUS, st_exp());
    chk_reg(`FRIE_OFS_STATE, 32'h1);
    chk_reg(12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("Reset and map test done");
    for (int i = 0; i < 128; i++)
    begin
      run_op(`FRIE_OP_LIT, 7'(i), 1'b0, 8'($urandom));
      run_op(`FRIE_OP_STORE, 7'(i), 1'b0, 8'h00);
    end
    $display("Fill test done");
    run_op(`FRIE_OP_LIT, 7'h00, 1'b0, 8'hff);
    run_op(`FRIE_OP_STORE, 7'h7f, 1'b1, 8'h00);
    run_op(`FRIE_OP_INC, 7'h7f, 1'b1, 8'h00);
    run_op(`FRIE_OP_MOVE, 7'h7f, 1'b1, 8'h00);
    run_op(`FRIE_OP_ROTL, 7'h7f, 1'b0, 8'h00);
    run_op(4'hf, 7'h7f, 1'b1, 8'h5a);
    $display("Corner test done");
    for (int i = 0; i < 300; i++)
    begin
      j = $urandom % 10;
      if (j == 9)
      begin
        apb(1'b1, `FRIE_OFS_STATUS, $urandom);
        {gie_m, z_m, c_m} = {pwdata[7], pwdata[2], pwdata[0]};
        apb(1'b1, `FRIE_OFS_WREG, $urandom);
        w_m = pwdata[7:0];
        chk_reg(`FRIE_OFS_STATUS, st_exp());
      end
      else
        run_op(ops[j], 7'($urandom), 1'($urandom), 8'($urandom));
    end
    $display("Random test done");
    frie_fetch_model_i.issue(`FRIE_OP_SLEEP, 7'h00, 1'b0, 8'h00, 0);
    do @(posedge pclk); while (sleep_active !== 1'b1);
    repeat (6) @(posedge pclk);
    chk({31'h0, instr_ready}, 32'h0);
    wake_req <= 1'b1;
    do @(posedge pclk); while (instr_ready !== 1'b1);
    wake_req <= 1'b0;
    pd_m = 1'b0;
    chk_reg(`FRIE_OFS_STATUS, st_exp());
    $display("Sleep test done");
    for (int i = 0; i < 128; i++)
      run_op(`FRIE_OP_MOVE, 7'(i), 1'b0, 8'h00);
    $display("Sweep test done");
    tally_and_finish();
  end
endmodule // frie_exec_tb
`default_nettype wire
